// ---- design/bmc_mode_ctrl.sv ----
// How it works
// - High byte writable except bits 12-10, low byte read-only.
// - Bits 0-6 zero, bit 7 not writable.
// - Relearn set on reset/20 cycles, cleared learning.
// - Alarm inhibit blocks mastering and warnings.
// - Inhibit clear: warn host and charger.
// - Alarm broadcasts at least ten seconds apart.
// - Mode command restarts sixty-second inhibit timer.
// - Timer expiry re-enables alarm broadcasts.
// - Sleep clears unit and both inhibits.
// - Alarm timer leaves charger inhibit alone.
// - Bit 14 stops charging parameter broadcasts.
// - Bit 15 selects 10 mW units.
// - Capacity values use selected units.
// - Derived results computed in selected units.
// - Unit change refreshes non-rate values immediately.
// - Rate results switch units at refresh.
// - Rate refresh within 5 ms, every second.
`timescale 1ns/1ps
`include "bmc_defs.svh"

module bmc_mode_ctrl #(
  parameter int unsigned TICK_CYCLES = `BMC_TICK_CYCLES,
  parameter int unsigned ALARM_HOLD_MS = `BMC_ALARM_HOLD_MS,
  parameter int unsigned ALARM_GAP_MS = `BMC_ALARM_GAP_MS,
  parameter int unsigned RATE_PERIOD_MS = `BMC_RATE_PERIOD_MS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Word command port from the serial front end
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  // Gauge events
  input wire logic sleep_enter_i,
  input wire logic cycle_inc_i,
  input wire logic fcc_update_i,
  input wire logic learn_done_i,
  input wire logic alarm_cond_i,
  input wire logic charge_due_i,
  // Mode effects
  output logic [15:0] mode_word_o,
  output logic bus_master_en_o,
  output logic alarm_send_o,
  output logic charge_send_o,
  output logic unit_power_o,
  output logic unit_change_o,
  output logic rate_unit_power_o,
  output logic rate_refresh_o
);

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES);
  localparam logic [4:0] RELEARN_LAST = 5'(`BMC_RELEARN_CYCLES - 1);

  logic [DIV_W-1:0] div_q, div_d;
  logic tick;
  logic [7:0] hi_q, hi_d;
  logic relearn_q, relearn_d;
  logic [4:0] cyc_q, cyc_d;
  bmc_pkg::bmc_ms_t hold_q, hold_d;
  bmc_pkg::bmc_ms_t gap_q, gap_d;
  bmc_pkg::bmc_ms_t per_q, per_d;
  logic alarm_q, alarm_d;
  logic charge_q, charge_d;
  logic uchg_q, uchg_d;
  logic rref_q, rref_d;
  logic runit_q, runit_d;
  bmc_pkg::bmc_word_t rdata_q, rdata_d;
  logic mode_cmd, mode_wr, rate_wr;
  bmc_pkg::bmc_word_t word;

  assign tick = (div_q == DIV_W'(TICK_CYCLES - 1));
  assign mode_cmd = cmd_valid_i && (cmd_code_i == `BMC_CMD_MODE);
  assign mode_wr = mode_cmd && cmd_write_i;
  assign rate_wr = cmd_valid_i && cmd_write_i
                   && (cmd_code_i == `BMC_CMD_RATE);

  assign word = {hi_q, relearn_q, 7'h00};

  always_comb begin
    div_d = tick ? '0 : div_q + DIV_W'(1);
    hi_d = hi_q;
    hold_d = hold_q;
    if (mode_wr) begin
      hi_d = cmd_wdata_i[15:8] & `BMC_HI_WR_MASK;
    end
    if (mode_cmd) begin
      hold_d = 16'(ALARM_HOLD_MS);
    end else if (tick && hold_q != '0) begin
      hold_d = hold_q - 16'h0001;
      if (hold_q == 16'h0001) begin
        hi_d[`BMC_HI_ALM_INH] = 1'b0;
      end
    end
    // Sleep wins over a write of bits 15..13 in the same cycle, since the gauge has
    // already committed to low power with default modes.
    // sleep defaults
    if (sleep_enter_i) begin
      hi_d[`BMC_HI_UNIT] = 1'b0;
      hi_d[`BMC_HI_CHG_INH] = 1'b0;
      hi_d[`BMC_HI_ALM_INH] = 1'b0;
    end
  end

  always_comb begin
    cyc_d = cyc_q;
    relearn_d = relearn_q;
    if (fcc_update_i || learn_done_i) begin
      cyc_d = '0;
    end else if (cycle_inc_i && cyc_q != RELEARN_LAST) begin
      cyc_d = cyc_q + 5'h01;
    end
    if (learn_done_i) begin
      relearn_d = 1'b0;
    end
    // A cycle count that lands with a learn completion still requests.
    if (cycle_inc_i && !fcc_update_i && cyc_q == RELEARN_LAST) begin
      relearn_d = 1'b1;
      cyc_d = '0;
    end
  end

  always_comb begin
    gap_d = gap_q;
    alarm_d = 1'b0;
    if (tick && gap_q != '0) begin
      gap_d = gap_q - 16'h0001;
    end
    if (alarm_cond_i && !hi_q[`BMC_HI_ALM_INH] && gap_q == '0) begin
      alarm_d = 1'b1;
      gap_d = 16'(ALARM_GAP_MS);
    end
    charge_d = charge_due_i && !hi_q[`BMC_HI_CHG_INH];
    uchg_d = hi_d[`BMC_HI_UNIT] != hi_q[`BMC_HI_UNIT];
  end

  always_comb begin
    per_d = per_q;
    rref_d = 1'b0;
    runit_d = runit_q;
    if (tick) begin
      if (per_q == 16'(RATE_PERIOD_MS - 1)) begin
        per_d = '0;
        rref_d = 1'b1;
      end else begin
        per_d = per_q + 16'h0001;
      end
    end
    if (rate_wr) begin
      rref_d = 1'b1;
    end
    if (rref_d) begin
      runit_d = hi_q[`BMC_HI_UNIT];
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (mode_cmd && !cmd_write_i) begin
      rdata_d = word;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_q <= '0;
      hi_q <= `BMC_HI_RESET;
      relearn_q <= 1'b1;
      cyc_q <= '0;
      hold_q <= '0;
      gap_q <= '0;
      per_q <= '0;
      alarm_q <= 1'b0;
      charge_q <= 1'b0;
      uchg_q <= 1'b0;
      rref_q <= 1'b0;
      runit_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      div_q <= div_d;
      hi_q <= hi_d;
      relearn_q <= relearn_d;
      cyc_q <= cyc_d;
      hold_q <= hold_d;
      gap_q <= gap_d;
      per_q <= per_d;
      alarm_q <= alarm_d;
      charge_q <= charge_d;
      uchg_q <= uchg_d;
      rref_q <= rref_d;
      runit_q <= runit_d;
      rdata_q <= rdata_d;
    end
  end

  assign cmd_rdata_o = rdata_q;
  assign mode_word_o = word;
  assign bus_master_en_o = !hi_q[`BMC_HI_ALM_INH];
  assign alarm_send_o = alarm_q;
  assign charge_send_o = charge_q;
  assign unit_power_o = hi_q[`BMC_HI_UNIT];
  assign unit_change_o = uchg_q;
  assign rate_unit_power_o = runit_q;
  assign rate_refresh_o = rref_q;

endmodule : bmc_mode_ctrl

// ---- design/bmc_defs.svh ----
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// Command codes seen by the mode block.
`define BMC_CMD_MODE 8'h03
`define BMC_CMD_RATE 8'h04

// Field positions inside the high (writable) byte of the mode word.
`define BMC_HI_UNIT 7
`define BMC_HI_CHG_INH 6
`define BMC_HI_ALM_INH 5
// Writable bits of the high byte: 15..13 and 9..8; 12..10 read as zero.
`define BMC_HI_WR_MASK 8'he3
`define BMC_HI_RESET 8'h00

// Relearn request bit inside the low byte.
`define BMC_LO_RELEARN 7
`define BMC_RELEARN_CYCLES 20

// Timing.
`define BMC_CLK_NS 10
`define BMC_TICK_NS 1000000
`define BMC_TICK_CYCLES (`BMC_TICK_NS / `BMC_CLK_NS)
`define BMC_ALARM_HOLD_MS 60000
`define BMC_ALARM_GAP_MS 10000
`define BMC_RATE_PERIOD_MS 1000

`endif

// ---- design/bmc_pkg.sv ----
package bmc_pkg;
  typedef logic [15:0] bmc_word_t;
  typedef logic [15:0] bmc_ms_t;
endpackage : bmc_pkg

// ---- verif/bmc_mode_sva.sv ----
`timescale 1ns/1ps
module bmc_mode_sva (
  input logic clk_sys_i, srst_i, cmd_valid_i, cmd_write_i,
  input logic [7:0] cmd_code_i,
  input logic [15:0] cmd_wdata_i, mode_word_o,
  input logic sleep_enter_i, learn_done_i, cycle_inc_i,
  input logic alarm_cond_i, alarm_send_o, charge_due_i,
  input logic charge_send_o, unit_change_o, rate_refresh_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  wire wr = cmd_valid_i && cmd_write_i;
  a_low_zero: assert property (
    mode_word_o[6:0] == 7'h00) else $error("low bits");
  a_hi_write: assert property (
    wr && cmd_code_i == 8'h03 && !sleep_enter_i |=>
    mode_word_o[15:13] == $past(cmd_wdata_i[15:13])) else $error("write");
  a_sleep_clr: assert property (
    sleep_enter_i |=> mode_word_o[15:13] == 3'h0) else $error("sleep");
  a_inh_quiet: assert property (
    alarm_send_o |-> !$past(mode_word_o[13]) && $past(alarm_cond_i))
    else $error("alarm sent");
  a_alarm_gap: assert property (
    alarm_send_o |=> !alarm_send_o [*8]) else $error("gap");
  a_charge_gate: assert property (
    charge_send_o == ($past(charge_due_i) && !$past(mode_word_o[14])))
    else $error("charge");
  a_unit_pulse: assert property (
    unit_change_o == $changed(mode_word_o[15])) else $error("unit");
  a_rate_soon: assert property (
    wr && cmd_code_i == 8'h04 |-> ##1 rate_refresh_o) else $error("rate");
  a_relearn_clr: assert property (
    learn_done_i && !cycle_inc_i |=> !mode_word_o[7]) else $error("learn");
  c_alarm: cover property (alarm_send_o);
  c_unit: cover property (unit_change_o);
  c_sleep: cover property (sleep_enter_i ##1 !mode_word_o[15]);
endmodule : bmc_mode_sva
bind bmc_mode_ctrl bmc_mode_sva u_sva (.*);

// ---- verif/bmc_far_end.sv ----
`timescale 1ns/1ps
// Host and charger: they only count the messages they receive.
module bmc_far_end (
  input logic clk_sys_i, alarm_i, charge_i,
  output int alarm_cnt_o = 0,
  output int charge_cnt_o = 0
);
  always @(posedge clk_sys_i) begin
    if (alarm_i) alarm_cnt_o <= alarm_cnt_o + 1;
    if (charge_i) charge_cnt_o <= charge_cnt_o + 1;
  end
endmodule : bmc_far_end

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i = 0, srst_i = 1, cmd_valid_i = 0, cmd_write_i = 0;
  logic [7:0] cmd_code_i = 8'h00;
  logic [15:0] cmd_wdata_i = 16'h0000, cmd_rdata_o, mode_word_o, w;
  logic [5:0] ev = 6'h00;
  logic bus_master_en_o, alarm_send_o, charge_send_o, unit_power_o;
  logic unit_change_o, rate_unit_power_o, rate_refresh_o, rd_q = 0;
  logic [15:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_al, n_ch;
  int seed = 32'h4a7d0cd5;
  always #5 clk_sys_i = ~clk_sys_i;
  bmc_mode_ctrl #(.TICK_CYCLES(4), .ALARM_HOLD_MS(20), .ALARM_GAP_MS(5),
    .RATE_PERIOD_MS(8)) dut (.*, .sleep_enter_i(ev[0]),
    .cycle_inc_i(ev[1]), .fcc_update_i(ev[2]), .learn_done_i(ev[3]),
    .alarm_cond_i(ev[4]), .charge_due_i(ev[5]));
  bmc_far_end far (.clk_sys_i(clk_sys_i), .alarm_i(alarm_send_o),
    .charge_i(charge_send_o), .alarm_cnt_o(n_al), .charge_cnt_o(n_ch));
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task cmd(input logic r, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_i);
    {cmd_valid_i, cmd_write_i, cmd_code_i, cmd_wdata_i} <= {1'b1, r, c, d};
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
  endtask : cmd
  task rd(input logic [15:0] e);
    exp_q.push_back(e);
    cmd(1'b0, 8'h03, 16'h0000);
  endtask : rd
  task hold(input logic [5:0] m, input int n);
    @(posedge clk_sys_i);
    ev <= m;
    repeat (n) @(posedge clk_sys_i);
    ev <= 6'h00;
  endtask : hold
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Read data lands one edge after the read is taken.
  always @(negedge clk_sys_i) begin
    if (rd_q) chk(cmd_rdata_o, exp_q.pop_front());
    rd_q = cmd_valid_i && !cmd_write_i && cmd_code_i == 8'h03;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(16'h0080);
    hold(6'h10, 30);
    chk(16'(n_al), 16'h0002);
    cmd(1'b1, 8'h03, 16'h6000);
    hold(6'h10, 30);
    chk(16'(n_al), 16'h0002);
    hold(6'h20, 1);
    repeat (100) @(posedge clk_sys_i);
    chk(16'(n_ch), 16'h0000);
    rd(16'h4080);
    hold(6'h01, 1);
    rd(16'h0080);
    hold(6'h20, 1);
    repeat (3) @(posedge clk_sys_i);
    chk(16'(n_ch), 16'h0001);
    hold(6'h08, 1);
    rd(16'h0000);
    repeat (20) hold(6'h02, 1);
    rd(16'h0080);
    cmd(1'b1, 8'h04, 16'h0000);
    // host keeps the alarm inhibit alive by rewriting it in time.
    cmd(1'b1, 8'h03, 16'h2000);
    repeat (60) @(posedge clk_sys_i);
    cmd(1'b1, 8'h03, 16'h2000);
    repeat (60) @(posedge clk_sys_i);
    chk({15'h0000, bus_master_en_o}, 16'h0000);
    repeat (40) @(posedge clk_sys_i);
    chk({15'h0000, bus_master_en_o}, 16'h0001);
    repeat (4) begin
      w = 16'($random(seed));
      cmd(1'b1, 8'h03, w);
      cmd(1'b1, 8'h05, ~w);
      rd({w[15:8] & 8'he3, 8'h80});
      chk({15'h0000, unit_power_o}, {15'h0000, w[15]});
    end
    repeat (3) @(posedge clk_sys_i);
    end_of_test();
  end
endmodule : testbench
